// ---- common/tbtc_regs.vh ----
// Register map, field positions and reset values of the paired timer control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses; included by the design file.
`ifndef TBTC_REGS_VH
`define TBTC_REGS_VH

// Byte offsets of the word registers
`define TBTC_OFS_CTL_EVEN   4'h0
`define TBTC_OFS_CTL_ODD    4'h4
`define TBTC_OFS_CNT_EVEN   4'h8
`define TBTC_OFS_CNT_ODD    4'hc

// Field positions in timer_control
`define TBTC_BIT_ON         15
`define TBTC_BIT_IDLE_STOP  13
`define TBTC_BIT_GATE       7
`define TBTC_BIT_PS_HI      6
`define TBTC_BIT_PS_LO      4
`define TBTC_BIT_PAIR       3
`define TBTC_BIT_CS         1

// Reset values
`define TBTC_RST_CTL        16'h0000
`define TBTC_RST_CNT        16'h0000
`define TBTC_RST_PSC        8'h00

// Prescaler terminal counts (divisor minus one)
`define TBTC_PSC_DIV1       8'h00
`define TBTC_PSC_DIV2       8'h01
`define TBTC_PSC_DIV4       8'h03
`define TBTC_PSC_DIV8       8'h07
`define TBTC_PSC_DIV16      8'h0f
`define TBTC_PSC_DIV32      8'h1f
`define TBTC_PSC_DIV64      8'h3f
`define TBTC_PSC_DIV256     8'hff

`endif

// ---- design/tbtc_timer.v ----
// Even/odd timer pair with control registers, prescalers and 32-bit pairing.
// Assumes an Avalon-MM master on clk_i; gate and timer clock pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tbtc_regs.vh"

module tbtc_timer
(
  input  wire        clk_i,            // Peripheral bus clock, 40 MHz
  input  wire        nrst_i,           // Asynchronous reset, active low
  input  wire [3:0]  address_i,        // Avalon byte address
  input  wire        read_i,           // Avalon read request
  input  wire        write_i,          // Avalon write request
  input  wire [31:0] writedata_i,      // Avalon write data
  input  wire [3:0]  byteenable_i,     // Avalon byte lanes
  output reg  [31:0] readdata_o,       // Avalon read data
  output wire        waitrequest_o,    // Avalon wait
  input  wire        idle_i,           // Device Idle mode, same clock domain
  input  wire        gate_even_i,      // Gate pin of even timer
  input  wire        gate_odd_i,       // Gate pin of odd timer
  input  wire        tclk_even_i,      // External clock pin of even timer
  input  wire        tclk_odd_i,       // External clock pin of odd timer
  output reg         wrap_even_o,      // Even counter rolled over while unpaired, pulse
  output reg         wrap_odd_o        // Odd counter (or pair) rolled over, pulse
);

  // Control fields, index 0 even timer, 1 odd timer
  reg  [1:0]  on;                      // Enable bits
  reg  [1:0]  idle_stop;               // Stop in Idle bits
  reg  [1:0]  gate_accumulate_en;      // Gate bits as written
  reg  [1:0]  clock_source_sel;        // Source select bits
  reg  [2:0]  input_prescale_sel_e;    // Even prescale select
  reg  [2:0]  input_prescale_sel_o;    // Odd prescale select
  reg         pair_32bit_mode;         // Only on even timer
  reg  [15:0] cnt_e;                   // Even counter
  reg  [15:0] cnt_o;                   // Odd counter, upper half when paired
  reg  [7:0]  psc_e;                   // Even prescaler
  reg  [7:0]  psc_o;                   // Odd prescaler
  reg         ack;                     // Second cycle of a bus access

  // Pin synchronisers and edge history
  reg  [3:0]  pin_s1;                  // First stage, read only by second
  reg  [3:0]  pin_s2;                  // Second stage
  reg  [1:0]  tclk_d;                  // Delayed timer clocks for edges

  // Combinational next values
  reg  [15:0] next_cnt_e;
  reg  [15:0] next_cnt_o;
  reg  [7:0]  next_psc_e;
  reg  [7:0]  next_psc_o;
  reg         next_wrap_e;
  reg         next_wrap_o;
  reg         tick_e;                  // Even count step this cycle
  reg         tick_o;                  // Odd own count step this cycle
  reg  [31:0] next_rdata;              // Read data to register

  wire        gate_e_s  = pin_s2[0];
  wire        gate_o_s  = pin_s2[1];
  wire        tclk_e_s  = pin_s2[2];
  wire        tclk_o_s  = pin_s2[3];
  wire        rise_e    = tclk_e_s & ~tclk_d[0];
  wire        rise_o    = tclk_o_s & ~tclk_d[1];
  wire        bus_req   = read_i | write_i;
  wire        wr_go     = write_i & ack;

  // Terminal count of the prescaler for a select code
  function [7:0] psc_term;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    psc_term = `TBTC_PSC_DIV1;
        3'h1:    psc_term = `TBTC_PSC_DIV2;
        3'h2:    psc_term = `TBTC_PSC_DIV4;
        3'h3:    psc_term = `TBTC_PSC_DIV8;
        3'h4:    psc_term = `TBTC_PSC_DIV16;
        3'h5:    psc_term = `TBTC_PSC_DIV32;
        3'h6:    psc_term = `TBTC_PSC_DIV64;
        default: psc_term = `TBTC_PSC_DIV256;
      endcase
    end
  endfunction

  // Whether the input clock may reach the prescaler
  function src_ok;
    input cs;
    input gate_en;
    input gate_pin;
    input ext_rise;
    begin
      if (cs)
        src_ok = ext_rise;
      else
        src_ok = ~gate_en | gate_pin;
    end
  endfunction

  // Control register image as software reads it
  function [31:0] ctl_image;
    input        en;
    input        stop_idle;
    input        gate_en;
    input [2:0]  ps;
    input        pair;
    input        cs;
    begin
      ctl_image = 32'h0000_0000;
      ctl_image[`TBTC_BIT_ON]        = en;
      ctl_image[`TBTC_BIT_IDLE_STOP] = stop_idle;
      ctl_image[`TBTC_BIT_GATE]      = gate_en & ~cs;
      ctl_image[`TBTC_BIT_PS_HI:`TBTC_BIT_PS_LO] = ps;
      ctl_image[`TBTC_BIT_PAIR]      = pair;
      ctl_image[`TBTC_BIT_CS]        = cs;
    end
  endfunction

  // Byte-lane merge for 16-bit counters
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  be;
    begin
      merge16 = old;
      if (be[0])
        merge16[7:0] = wd[7:0];
      if (be[1])
        merge16[15:8] = wd[15:8];
    end
  endfunction

  // One wait cycle per access; the answer comes on the second edge
  assign waitrequest_o = bus_req & ~ack;

  // Synchronise asynchronous pins through two flops
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      tclk_d <= 2'h0;
    end
    else
    begin
      pin_s1 <= {tclk_odd_i, tclk_even_i, gate_odd_i, gate_even_i};
      pin_s2 <= pin_s1;
      tclk_d <= {tclk_o_s, tclk_e_s};  // Edge detect uses second stage only
    end
  end

  // Count steps: prescaler and counters for both halves
  always @*
  begin
    next_psc_e  = psc_e;
    next_psc_o  = psc_o;
    next_cnt_e  = cnt_e;
    next_cnt_o  = cnt_o;
    next_wrap_e = 1'b0;
    next_wrap_o = 1'b0;
    tick_e      = 1'b0;
    tick_o      = 1'b0;
    // Even timer steered by its own control; when paired the odd Stop in Idle bit also halts it
    if (!on[0])
      next_psc_e = `TBTC_RST_PSC;
    else if (!(idle_i & idle_stop[0]) &&
             !(pair_32bit_mode & idle_i & idle_stop[1]) &&
             src_ok(clock_source_sel[0], gate_accumulate_en[0], gate_e_s, rise_e))
    begin
      if (psc_e == psc_term(input_prescale_sel_e))
      begin
        next_psc_e = `TBTC_RST_PSC;
        tick_e     = 1'b1;
      end
      else
        next_psc_e = psc_e + 8'h01;
    end
    if (tick_e)
    begin
      next_cnt_e  = cnt_e + 16'h0001;
      next_wrap_e = (cnt_e == 16'hffff) & ~pair_32bit_mode;
    end
    // Odd timer: chained, or on its own control
    if (pair_32bit_mode)
    begin
      next_psc_o = `TBTC_RST_PSC;
      if (tick_e && cnt_e == 16'hffff)
      begin
        next_cnt_o  = cnt_o + 16'h0001;
        next_wrap_o = (cnt_o == 16'hffff);
      end
    end
    else
    begin
      if (!on[1])
        next_psc_o = `TBTC_RST_PSC;
      else if (!(idle_i & idle_stop[1]) &&
               src_ok(clock_source_sel[1], gate_accumulate_en[1], gate_o_s, rise_o))
      begin
        if (psc_o == psc_term(input_prescale_sel_o))
        begin
          next_psc_o = `TBTC_RST_PSC;
          tick_o     = 1'b1;
        end
        else
          next_psc_o = psc_o + 8'h01;
      end
      if (tick_o)
      begin
        next_cnt_o  = cnt_o + 16'h0001;
        next_wrap_o = (cnt_o == 16'hffff);
      end
    end
  end

  // Read data mux; unmapped addresses return zero
  always @*
  begin
    case (address_i)
      `TBTC_OFS_CTL_EVEN:
        next_rdata = ctl_image(on[0], idle_stop[0], gate_accumulate_en[0],
                               input_prescale_sel_e, pair_32bit_mode,
                               clock_source_sel[0]);
      `TBTC_OFS_CTL_ODD:
        next_rdata = ctl_image(on[1], idle_stop[1], gate_accumulate_en[1],
                               input_prescale_sel_o, 1'b0,
                               clock_source_sel[1]);
      `TBTC_OFS_CNT_EVEN:
        next_rdata = {16'h0000, cnt_e};
      `TBTC_OFS_CNT_ODD:
        next_rdata = {16'h0000, cnt_o};
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus handshake and read data capture
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack        <= 1'b0;
      readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack <= bus_req & ~ack;
      // Sample in the wait cycle so data stand at the answering edge
      if (read_i && !ack)
        readdata_o <= next_rdata;
    end
  end

  // Control registers; writes land at the answering edge
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      on                   <= 2'h0;
      idle_stop            <= 2'h0;
      gate_accumulate_en   <= 2'h0;
      clock_source_sel     <= 2'h0;
      input_prescale_sel_e <= 3'h0;
      input_prescale_sel_o <= 3'h0;
      pair_32bit_mode      <= 1'b0;
    end
    else if (wr_go)
    begin
      if (address_i == `TBTC_OFS_CTL_EVEN)
      begin
        if (byteenable_i[1])
        begin
          on[0]        <= writedata_i[`TBTC_BIT_ON];
          idle_stop[0] <= writedata_i[`TBTC_BIT_IDLE_STOP];
        end
        if (byteenable_i[0])
        begin
          gate_accumulate_en[0] <= writedata_i[`TBTC_BIT_GATE];
          input_prescale_sel_e  <= writedata_i[`TBTC_BIT_PS_HI:`TBTC_BIT_PS_LO];
          pair_32bit_mode       <= writedata_i[`TBTC_BIT_PAIR];
          clock_source_sel[0]   <= writedata_i[`TBTC_BIT_CS];
        end
      end
      else if (address_i == `TBTC_OFS_CTL_ODD)
      begin
        // Odd fields are stored even when paired; all but the odd Stop in Idle bit then go unused
        if (byteenable_i[1])
        begin
          on[1]        <= writedata_i[`TBTC_BIT_ON];
          idle_stop[1] <= writedata_i[`TBTC_BIT_IDLE_STOP];
        end
        if (byteenable_i[0])
        begin
          gate_accumulate_en[1] <= writedata_i[`TBTC_BIT_GATE];
          input_prescale_sel_o  <= writedata_i[`TBTC_BIT_PS_HI:`TBTC_BIT_PS_LO];
          clock_source_sel[1]   <= writedata_i[`TBTC_BIT_CS];
        end
      end
    end
  end

  // Counters and prescalers; a software write beats a count step
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_e       <= `TBTC_RST_CNT;
      cnt_o       <= `TBTC_RST_CNT;
      psc_e       <= `TBTC_RST_PSC;
      psc_o       <= `TBTC_RST_PSC;
      wrap_even_o <= 1'b0;
      wrap_odd_o  <= 1'b0;
    end
    else
    begin
      psc_e       <= next_psc_e;
      psc_o       <= next_psc_o;
      wrap_even_o <= next_wrap_e;
      wrap_odd_o  <= next_wrap_o;
      if (wr_go && address_i == `TBTC_OFS_CNT_EVEN)
        cnt_e <= merge16(cnt_e, writedata_i[15:0], byteenable_i[1:0]);
      else
        cnt_e <= next_cnt_e;
      if (wr_go && address_i == `TBTC_OFS_CNT_ODD)
        cnt_o <= merge16(cnt_o, writedata_i[15:0], byteenable_i[1:0]);
      else
        cnt_o <= next_cnt_o;
    end
  end

endmodule

`default_nettype wire

// ---- verif/tbtc_timer_chk.sv ----
// Checker for the timer pair: control readback and even wrap pulse timing.
// Sees only top ports; bound to every tbtc_timer instance below.
`timescale 1ns/1ps
`default_nettype none
module tbtc_chk
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [3:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        idle_i,
  input wire logic        wrap_even_o
);
  logic [15:0] ctl;                                    // Shadow of even control
  wire         rd = read_i && !waitrequest_o;          // Read answer cycle
  wire  [15:0] xp = {ctl[15:8], ctl[7] & ~ctl[1], ctl[6:0]}; // Expected readback
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Shadow keeps only implemented bits, so readback compares whole
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      ctl <= 16'h0000;
    else if (write_i && !waitrequest_o && address_i == 4'h0)
    begin
      if (byteenable_i[1])
        ctl[15:8] <= writedata_i[15:8] & 8'ha0;
      if (byteenable_i[0])
        ctl[7:0] <= writedata_i[7:0] & 8'hfa;
    end
  property p_rback; rd && address_i == 4'h0 |-> readdata_o == {16'h0000, xp}; endproperty
  a_rback: assert property (p_rback) else $error("even control readback");
  property p_odd_unimp; rd && address_i == 4'h4 |-> (readdata_o & 32'hffff5f05) == 0; endproperty
  a_odd_unimp: assert property (p_odd_unimp) else $error("odd reserved bits");
  property p_odd_pair; rd && address_i == 4'h4 |-> !readdata_o[3]; endproperty
  a_odd_pair: assert property (p_odd_pair) else $error("odd pair bit set");
  property p_gate; rd && !address_i[3] && readdata_o[1] |-> !readdata_o[7]; endproperty
  a_gate: assert property (p_gate) else $error("gate bit read with ext");
  property p_gap; wrap_even_o |=> !wrap_even_o [*8]; endproperty
  a_gap: assert property (p_gap) else $error("wrap pulses too close");
  property p_pair; ctl[3] && $past(ctl[3]) |-> !wrap_even_o; endproperty
  a_pair: assert property (p_pair) else $error("even wrap while paired");
  property p_off; !ctl[15] && !$past(ctl[15]) && !$past(ctl[15], 2) |-> !wrap_even_o; endproperty
  a_off: assert property (p_off) else $error("wrap while disabled");
  property p_idle;
    idle_i && $past(idle_i) && $past(idle_i, 2) && ctl[13] && $past(ctl[13]) |-> !wrap_even_o;
  endproperty
  a_idle: assert property (p_idle) else $error("wrap in idle stop");
endmodule
bind tbtc_timer tbtc_chk chk (.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .idle_i(idle_i),
  .wrap_even_o(wrap_even_o));
`default_nettype wire

// ---- verif/tbtc_pins.sv ----
// Far-side model: gate levels and external timer clocks.
// Assumes the bench sets run and gate levels between counting windows.
`timescale 1ns/1ps
`default_nettype none
module tbtc_pins
(
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic gate_i,
  output wire logic gate_even_o,
  output wire logic gate_odd_o,
  output wire logic tclk_even_o,
  output wire logic tclk_odd_o
);
  logic [2:0] ph = 3'h0;              // One pin clock per 8 bus clocks
  // Pin clock stands low when not asked to run
  always @(posedge clk_i)
    ph <= ph + 3'h1;
  assign tclk_even_o = run_i & ph[2];
  assign tclk_odd_o  = run_i & ~ph[2];
  assign gate_even_o = gate_i;
  assign gate_odd_o  = ~gate_i;
endmodule
`default_nettype wire

// ---- verif/type_b_timer_control_tb.sv ----
// Self-checking bench for the timer pair over Avalon-MM.
// Waits for waitrequest low at a rising edge; pin model drives gate and clock pins.
`timescale 1ns/1ps
`default_nettype none
module type_b_timer_control_tb;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  address_i = 4'h0;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic        idle_i = 1'b0;
  logic        run = 1'b0;
  logic        gate = 1'b0;
  logic [31:0] rv;
  wire  [31:0] readdata_o;
  wire         waitrequest_o, ge, go, te, to, we, wo;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n_wrap_e = 0;                // Even wrap pulses seen
  int          n_wrap_o = 0;                // Odd wrap pulses seen
  always #12.5 clk_i = ~clk_i;
  tbtc_timer DUT (.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hf),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .idle_i(idle_i),
    .gate_even_i(ge), .gate_odd_i(go), .tclk_even_i(te), .tclk_odd_i(to),
    .wrap_even_o(we), .wrap_odd_o(wo));
  tbtc_pins PINS (.clk_i(clk_i), .run_i(run), .gate_i(gate), .gate_even_o(ge),
    .gate_odd_o(go), .tclk_even_o(te), .tclk_odd_o(to));
  // Count wrap pulses; they stand one cycle, so sample every edge
  always @(posedge clk_i)
  begin
    if (we === 1'b1)
      n_wrap_e <= n_wrap_e + 1;
    if (wo === 1'b1)
      n_wrap_o <= n_wrap_o + 1;
  end
  // Bus access held until waitrequest is sampled low at a rising edge;
  // the leading edge wait leaves a free cycle between accesses
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    read_i <= !w;
    write_i <= w;
    @(posedge clk_i);
    while (waitrequest_o)
      @(posedge clk_i);
    rv = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic ck(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      $display("[ERR] %0t %s", $time, m);
      n_mismatch++;
    end
  endtask
  // Run even counter from zero for a window, then read it
  task automatic runc(input logic [31:0] c, input int n);
    acc(1'b1, 4'h8, 32'h0);
    acc(1'b1, 4'h0, c);
    repeat (n) @(posedge clk_i);
    acc(1'b1, 4'h0, 32'h0);
    acc(1'b0, 4'h8, 32'h0);
  endtask
  task automatic t_rst;
    for (int i = 0; i < 16; i += 4)
    begin
      acc(1'b0, 4'(i), 32'h0);
      ck(rv === 32'h0, "reset value");
    end
  endtask
  task automatic t_ctl;
    acc(1'b1, 4'h0, 32'hffffffff);
    acc(1'b0, 4'h0, 32'h0);
    ck(rv === 32'h0000a07a, "even control");
    acc(1'b1, 4'h4, 32'hffffffff);
    acc(1'b0, 4'h4, 32'h0);
    ck(rv === 32'h0000a072, "odd control");
    acc(1'b1, 4'h0, 32'h00000080);
    acc(1'b0, 4'h0, 32'h0);
    ck(rv === 32'h00000080, "gate bit");
    acc(1'b1, 4'h0, 32'h0);
    acc(1'b1, 4'h4, 32'h0);
  endtask
  // Each prescale step should give about eight counts
  task automatic t_psc;
    int d;
    for (int s = 0; s < 8; s++)
    begin
      d = (s == 7) ? 256 : (1 << s);
      runc(32'h8000 | (32'(s) << 4), 8 * d + d / 2 - 3);
      ck(rv >= 7 && rv <= 9, "prescale count");
    end
  endtask
  task automatic t_gate;
    runc(32'h8080, 30);
    ck(rv === 32'h0, "gate low count");
    gate <= 1'b1;
    runc(32'h8080, 30);
    ck(rv >= 30 && rv <= 35, "gate high count");
    gate <= 1'b0;
    runc(32'h8000, 30);
    ck(rv >= 30 && rv <= 35, "ungated count");
    run <= 1'b1;
    runc(32'h8082, 78);
    ck(rv >= 9 && rv <= 11, "pin clock count");
    run <= 1'b0;
  endtask
  task automatic t_idle;
    idle_i <= 1'b1;
    runc(32'h8000, 20);
    ck(rv >= 20 && rv <= 25, "run in idle");
    acc(1'b1, 4'h8, 32'hfff8);
    acc(1'b1, 4'h0, 32'ha000);
    repeat (20) @(posedge clk_i);
    acc(1'b0, 4'h8, 32'h0);
    ck(rv === 32'hfff8, "idle halt");
    idle_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    acc(1'b1, 4'h0, 32'h0);
    acc(1'b0, 4'h8, 32'h0);
    ck(rv >= 32'he && rv <= 32'h16, "wrap after idle");
    ck(n_wrap_e == 1, "even wrap pulse");
  endtask
  // Paired: odd setup must be ignored, carry goes to odd half
  task automatic t_pair;
    acc(1'b1, 4'h8, 32'hfff0);
    acc(1'b1, 4'hc, 32'hffff);
    acc(1'b1, 4'h4, 32'h0070);
    acc(1'b1, 4'h0, 32'h8008);
    repeat (30) @(posedge clk_i);
    acc(1'b1, 4'h0, 32'h0);
    acc(1'b0, 4'hc, 32'h0);
    ck(rv === 32'h0, "pair carry");
    acc(1'b0, 4'h8, 32'h0);
    ck(rv >= 32'he && rv <= 32'h18, "pair low half");
    ck(n_wrap_o == 1 && n_wrap_e == 1, "pair wrap pulses");
  endtask
  // Odd timer on its own control at 1:2, about sixteen counts
  task automatic t_odd;
    acc(1'b1, 4'hc, 32'h0);
    acc(1'b1, 4'h4, 32'h8010);
    repeat (29) @(posedge clk_i);
    acc(1'b1, 4'h4, 32'h0);
    acc(1'b0, 4'hc, 32'h0);
    ck(rv >= 15 && rv <= 17, "odd own count");
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_rst();
    t_ctl();
    t_psc();
    t_gate();
    t_idle();
    t_pair();
    t_odd();
    results();
  end
  // Watchdog well past the expected few thousand cycles
  initial
  begin
    #500000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
